// >>> testbench/scpl_far_model.sv
/* Host controller and upstream video timing model.
   Assumes the bench calls its tasks; it runs on its own delays. */
`timescale 1ns/1ps
`default_nettype none
module scpl_far_model (
	output logic sclk,
	output logic cs_n,
	output logic host_serial_in,
	output logic pclk,
	output logic h,
	input wire logic host_serial_out
);
	// Serial clock idles high; the parallel clock runs free, off the bench phase.
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		host_serial_in = 1'b1;
		h = 1'b0;
		pclk = 1'b0;
		#7;
		forever #160 pclk = ~pclk;
	end
	// One framed shift of 24 bits, MSB first; the answer is taken before each rise.
	task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
		#13 cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sclk = 1'b0;
			host_serial_in = tx[i];
			#200 rx[i] = host_serial_out;
			sclk = 1'b1;
			#120;
		end
		cs_n = 1'b1;
		host_serial_in = ~host_serial_in;
		#400;
	endtask : xfer
	// H changes only after a parallel clock fall and holds over the whole span.
	task automatic set_h(input logic v);
		@(negedge pclk) h = v;
	endtask : set_h
endmodule : scpl_far_model
`default_nettype wire

// >>> testbench/scpl_sva.sv
/* Port checker of the serializer control-pin block.
   Assumes it is bound into scpl_top and shares its clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module scpl_sva #(
	parameter int ADDR_W = 12
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PSLVERR_OUT,
	input wire logic MODE_TEST_IN,
	input wire logic CS_N_IN,
	input wire logic SHARED_SERIAL_OUT_PIN_OE_OUT,
	input wire logic PCLK_IN,
	input wire logic H_IN,
	input wire logic IO_PROCESSING_ENABLE_PIN_IN,
	input wire logic H_FLAG_OUT,
	input wire logic H_CONFIG_OUT,
	input wire logic SERIAL_OUTPUT_ENABLE_PIN_IN,
	input wire logic SER_BIT_IN,
	input wire logic SDO_P_OUT,
	input wire logic SDO_N_OUT,
	input wire logic SDO_OE_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	// Access phase of an APB transfer, and whether it hits one of the four words.
	wire logic acc = PSEL_IN && PENABLE_IN;
	wire logic hit = (PADDR_IN[ADDR_W-1:4] == '0) && (PADDR_IN[1:0] == 2'h0);
	// Parallel clock rises seen while H stays low, saturating at three.
	logic pclk_q;
	logic [1:0] h_low;
	always_ff @(posedge CLK_IN) begin
		pclk_q <= PCLK_IN;
		if (RST_IN || H_IN) begin
			h_low <= 2'h0;
		end else if (PCLK_IN && !pclk_q && h_low != 2'h3) begin
			h_low <= h_low + 2'h1;
		end
	end
	a_err_unmapped: assert property (acc && !hit |-> PSLVERR_OUT) else $error("unmapped access not refused");
	a_err_mapped: assert property (acc && hit |-> !PSLVERR_OUT) else $error("mapped access refused");
	a_err_when: assert property (PSLVERR_OUT |-> acc) else $error("error outside access phase");
	a_hcfg_write: assert property (acc && hit && PWRITE_IN && PADDR_IN[3:2] == 2'h0
		|-> ##2 H_CONFIG_OUT == $past(PWDATA_IN[0], 2)) else $error("convention bit not stored");
	a_test_drives: assert property (MODE_TEST_IN [*5] |-> SHARED_SERIAL_OUT_PIN_OE_OUT)
		else $error("scan output not driven");
	a_host_quiet: assert property ((!MODE_TEST_IN && CS_N_IN) [*6] |-> !SHARED_SERIAL_OUT_PIN_OE_OUT)
		else $error("host output driven while idle");
	a_flag_gated: assert property (!IO_PROCESSING_ENABLE_PIN_IN [*6] |-> !H_FLAG_OUT)
		else $error("flag set with processing off");
	a_flag_hlow: assert property (h_low == 2'h3 |-> !H_FLAG_OUT) else $error("flag set with H low");
	a_stage_off: assert property (!SERIAL_OUTPUT_ENABLE_PIN_IN [*5] |-> !SDO_OE_OUT)
		else $error("output stage not released");
	a_stage_on: assert property (SERIAL_OUTPUT_ENABLE_PIN_IN [*5] |-> SDO_OE_OUT) else $error("stage not driven");
	a_stage_pair: assert property (SDO_OE_OUT |-> SDO_P_OUT == $past(SER_BIT_IN) && SDO_N_OUT == !SDO_P_OUT)
		else $error("output pair not carrying the bit");
	c_refused: cover property (acc && !hit);
	c_scan: cover property (MODE_TEST_IN && SHARED_SERIAL_OUT_PIN_OE_OUT);
	c_flag: cover property ($rose(H_FLAG_OUT));
	c_stage_off: cover property ($fell(SDO_OE_OUT));
endmodule : scpl_sva
bind scpl_top scpl_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// >>> testbench/tb_top.sv
/* Self-checking bench of the serializer control-pin block.
   Assumes scpl_top, its checker and the far-side model. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, mode = 1'b0, oe_pin = 1'b1, io_en = 1'b0, sbit = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, sclk, cs_n, host_serial_in, pclk, h, host_serial_out, soe, hflag, hcfg, sp, sn, soe2;
	// The undriven serial line shows the inverse of the pin's value.
	wire logic line = soe ? host_serial_out : ~host_serial_out;
	int fail_count = 0;
	int n_checks = 0;
	always #20 clk = ~clk;
	scpl_top uut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.MODE_TEST_IN(mode), .SCLK_IN(sclk), .CS_N_IN(cs_n), .SHARED_SERIAL_IN_PIN_IN(host_serial_in),
		.SHARED_SERIAL_OUT_PIN_OUT(host_serial_out), .SHARED_SERIAL_OUT_PIN_OE_OUT(soe), .PCLK_IN(pclk), .H_IN(h),
		.IO_PROCESSING_ENABLE_PIN_IN(io_en), .H_FLAG_OUT(hflag), .H_CONFIG_OUT(hcfg),
		.SERIAL_OUTPUT_ENABLE_PIN_IN(oe_pin), .SER_BIT_IN(sbit), .SDO_P_OUT(sp), .SDO_N_OUT(sn), .SDO_OE_OUT(soe2));
	scpl_far_model far (.sclk(sclk), .cs_n(cs_n), .host_serial_in(host_serial_in), .pclk(pclk), .h(h), .host_serial_out(line));
	// Counts one comparison and reports a mismatch.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// One APB transfer: setup, then access until ready is seen.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			complete_run();
		end
	endtask : apb
	// Reads a word and compares its data and error response.
	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp, input logic e);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		chk(what, exp, rd);
		chk("error response", {31'h0000_0000, e}, {31'h0000_0000, err});
	endtask : rdc
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
	endtask : wr
	// Lets synchronised pins and the parallel clock settle.
	task automatic settle;
		repeat (20) @(posedge clk);
	endtask : settle
	initial begin
		logic [23:0] rx;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// Registers over APB and the serial host port.
		rdc("disable reset", 12'h000, 32'h0000_0000, 1'b0);
		rdc("unmapped", 12'h010, 32'h0000_0000, 1'b1);
		wr(12'h000, 32'hFFFF_A5A5);
		rdc("disable word", 12'h000, 32'h0000_A5A5, 1'b0);
		settle();
		chk("convention", 32'h0000_0001, {31'h0000_0000, hcfg});
		far.xfer({1'b1, 7'h00, 16'h0000}, rx);
		chk("serial read", 32'h0000_A5A5, {16'h0000, rx[15:0]});
		far.xfer({1'b0, 7'h00, 16'h5A5A}, rx);
		settle();
		rdc("serial write", 12'h000, 32'h0000_5A5A, 1'b0);
		rdc("last write", 12'h00C, 32'h0000_5A5A, 1'b0);
		chk("convention", 32'h0000_0000, {31'h0000_0000, hcfg});
		$display("register test done");
		// H flag against H, the enable pin and timing detection.
		io_en <= 1'b1;
		far.set_h(1'b1);
		settle();
		chk("flag high", 32'h0000_0001, {31'h0000_0000, hflag});
		rdc("status", 12'h008, 32'h0000_000E, 1'b0);
		wr(12'h004, 32'h0000_0001);
		settle();
		chk("flag detect", 32'h0000_0000, {31'h0000_0000, hflag});
		far.xfer({1'b1, 7'h01, 16'h0000}, rx);
		chk("serial control", 32'h0000_0001, {16'h0000, rx[15:0]});
		wr(12'h004, 32'h0000_0000);
		io_en <= 1'b0;
		settle();
		chk("flag gated", 32'h0000_0000, {31'h0000_0000, hflag});
		io_en <= 1'b1;
		far.set_h(1'b0);
		settle();
		chk("flag low", 32'h0000_0000, {31'h0000_0000, hflag});
		$display("timing flag test done");
		// Output stage enable and the differential pair.
		sbit <= 1'b1;
		settle();
		chk("stage on", 32'h0000_0005, {29'h0000_0000, soe2, sn, sp});
		oe_pin <= 1'b0;
		settle();
		chk("stage off", 32'h0000_0000, {31'h0000_0000, soe2});
		oe_pin <= 1'b1;
		$display("output stage test done");
		// Scan mode: the pins become a one-bit bypass path.
		mode <= 1'b1;
		settle();
		chk("scan drive", 32'h0000_0001, {31'h0000_0000, soe});
		far.xfer(24'hC3_5A96, rx);
		chk("bypass", {9'h000, 23'h61_AD4B}, {9'h000, rx[22:0]});
		mode <= 1'b0;
		settle();
		chk("host idle", 32'h0000_0000, {31'h0000_0000, soe});
		$display("scan test done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire

// >>> verilog/scpl_pkg.sv
/*
 * Package of the serializer control-pin block: register offsets, field
 * positions, reset values, serial framing lengths and the carrier types.
 * Assumes nothing of its surroundings; scpl_top refers to it by scope.
 */
`default_nettype none
package scpl_pkg;
	// Byte offsets of the bus-visible registers.
	localparam logic [7:0] OFF_PROC_DISABLE = 8'h00;
	localparam logic [7:0] OFF_CONTROL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_LAST_WRITE = 8'h0C;
	// Register numbers as seen through the serial host interface.
	localparam logic [6:0] SER_PROC_DISABLE = 7'h00;
	localparam logic [6:0] SER_CONTROL = 7'h01;
	localparam logic [6:0] SER_STATUS = 7'h02;
	// Field positions.
	localparam int H_CONFIG_BIT = 0;
	localparam int DETECT_SEL_BIT = 0;
	localparam int ST_TEST_MODE_BIT = 0;
	localparam int ST_OUT_EN_BIT = 1;
	localparam int ST_IO_EN_BIT = 2;
	localparam int ST_H_FLAG_BIT = 3;
	localparam int ST_SER_BUSY_BIT = 4;
	// Reset values and writable masks.
	localparam logic [15:0] PROC_DISABLE_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_MASK = 16'h0001;
	// Serial framing: a read flag and address, then one data word.
	localparam int SER_CMD_BITS = 8;
	localparam int SER_DATA_BITS = 16;
	localparam logic [4:0] SER_CMD_LAST = 5'h07;
	localparam logic [4:0] SER_DATA_LAST = 5'h0F;
	localparam logic [4:0] SER_COUNT_ZERO = 5'h00;
	localparam int SER_READ_FLAG_BIT = 7;
	// Serial host interface states, Gray coded in listing order; CMD to READ and WRITE to IDLE flip both bits.
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_CMD = 2'b01,
		SER_WRITE = 2'b11,
		SER_READ = 2'b10
	} scpl_ser_e;
	// Asynchronous pins that travel together through the synchroniser.
	typedef struct packed {
		logic mode_test;
		logic sclk;
		logic cs_n;
		logic host_serial_in;
		logic out_en;
		logic io_en;
		logic pclk;
		logic h;
	} scpl_pins_s;
	localparam int PIN_COUNT = 8;
	// Serial clock, select and data in start at their idle high levels, so no false edge follows reset.
	localparam logic [7:0] PINS_RESET = 8'h70;
endpackage : scpl_pkg
`default_nettype wire

// >>> verilog/scpl_top.sv
/*
 * Control-pin logic of a multi-rate video serializer: shared serial pins
 * for host register access or boundary-scan, the H timing flag, the
 * serial output stage enable, and an APB register slave.
 * Assumes one 25 MHz clock; every pin arrives asynchronously and is slow
 * enough against that clock for its edges to be found by sampling.
 */
// Chosen here: register access over APB and the register offsets.
// Behaviour
// - Host mode: serial out shifts register contents.
// - Test mode: serial out becomes scan TDO.
// - Host mode: serial in carries register writes.
// - Test mode: serial in becomes scan TDI.
// - H flag follows H input when enabled; control bit 0 set forces it low.
// - Host-writable H convention bit in register.
// - Enable pin low tristates both serial outputs.
// - Mode pin high selects test, low host.
`timescale 1ns/1ps
`default_nettype none
module scpl_top #(
	parameter int ADDR_W = 12
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// APB slave.
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Shared serial pins and mode select.
	input wire logic MODE_TEST_IN,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic SHARED_SERIAL_IN_PIN_IN,
	output logic SHARED_SERIAL_OUT_PIN_OUT,
	output logic SHARED_SERIAL_OUT_PIN_OE_OUT,
	// Video timing side.
	input wire logic PCLK_IN,
	input wire logic H_IN,
	input wire logic IO_PROCESSING_ENABLE_PIN_IN,
	output logic H_FLAG_OUT,
	output logic H_CONFIG_OUT,
	// Serial output stage.
	input wire logic SERIAL_OUTPUT_ENABLE_PIN_IN,
	input wire logic SER_BIT_IN,
	output logic SDO_P_OUT,
	output logic SDO_N_OUT,
	output logic SDO_OE_OUT
);
	// Refuse an address bus too narrow for the register map.
	if (ADDR_W < 4) begin : g_addr_check
		$error("ADDR_W must be at least 4");
	end

	// Synchroniser stages; the first is read only by the second.
	scpl_pkg::scpl_pins_s pin_raw;
	scpl_pkg::scpl_pins_s pin_meta;
	scpl_pkg::scpl_pins_s pin_sync;
	scpl_pkg::scpl_pins_s pin_prev;

	// Software-visible registers.
	logic [15:0] proc_disable;
	logic [15:0] control;
	logic [15:0] last_write;
	logic [31:0] prdata;

	// Serial host interface state.
	scpl_pkg::scpl_ser_e ser_state;
	logic [4:0] ser_count;
	logic [7:0] ser_cmd;
	logic [15:0] ser_shift_in;
	logic [15:0] ser_shift_out;
	logic ser_write_pulse;
	logic [6:0] ser_write_addr;
	logic [15:0] ser_write_data;

	// Scan bypass stage and its output latch.
	logic scan_bypass;
	logic scan_tdo;

	// Video-side registers.
	logic h_sampled;
	logic h_flag;
	logic sdo_data;

	// Gather the asynchronous pins into one carrier.
	assign pin_raw = '{
		mode_test: MODE_TEST_IN,
		sclk: SCLK_IN,
		cs_n: CS_N_IN,
		host_serial_in: SHARED_SERIAL_IN_PIN_IN,
		out_en: SERIAL_OUTPUT_ENABLE_PIN_IN,
		io_en: IO_PROCESSING_ENABLE_PIN_IN,
		pclk: PCLK_IN,
		h: H_IN
	};

	// Two-flop synchroniser per pin plus a third stage for edge finding.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pin_meta <= scpl_pkg::PINS_RESET;
			pin_sync <= scpl_pkg::PINS_RESET;
			pin_prev <= scpl_pkg::PINS_RESET;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Mode decode and edge detection on the synchronised pins.
	wire test_mode = pin_sync.mode_test;
	wire host_mode = ~pin_sync.mode_test;
	wire sclk_rise = pin_sync.sclk & ~pin_prev.sclk;
	wire sclk_fall = ~pin_sync.sclk & pin_prev.sclk;
	wire pclk_rise = pin_sync.pclk & ~pin_prev.pclk;
	wire cs_active = host_mode & ~pin_sync.cs_n;
	wire ser_in_bit = pin_sync.host_serial_in;

	// Serial framing decode.
	wire cmd_done = (ser_state == scpl_pkg::SER_CMD) && (ser_count == scpl_pkg::SER_CMD_LAST);
	wire data_done = (ser_count == scpl_pkg::SER_DATA_LAST);
	wire [7:0] cmd_full = {ser_cmd[6:0], ser_in_bit};
	wire cmd_is_read = cmd_full[scpl_pkg::SER_READ_FLAG_BIT];
	wire [6:0] cmd_addr = cmd_full[6:0];

	// Status word built from live state.
	wire [15:0] status;
	assign status = {
		11'h000,
		ser_state != scpl_pkg::SER_IDLE,
		h_flag,
		pin_sync.io_en,
		pin_sync.out_en,
		test_mode
	};

	// Register read selection for the serial host interface.
	wire [15:0] ser_read_word;
	assign ser_read_word = (cmd_addr == scpl_pkg::SER_PROC_DISABLE) ? proc_disable :
		(cmd_addr == scpl_pkg::SER_CONTROL) ? control :
		(cmd_addr == scpl_pkg::SER_STATUS) ? status : 16'h0000;

	// Serial host state machine, stepped by the host's clock edges.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ser_state <= scpl_pkg::SER_IDLE;
			ser_count <= scpl_pkg::SER_COUNT_ZERO;
			ser_cmd <= 8'h00;
			ser_shift_in <= 16'h0000;
		end else if (!cs_active) begin
			// Deselect or test mode aborts any partial frame.
			ser_state <= scpl_pkg::SER_IDLE;
			ser_count <= scpl_pkg::SER_COUNT_ZERO;
		end else if (sclk_rise) begin
			case (ser_state)
				scpl_pkg::SER_IDLE: begin
					ser_cmd <= {7'h00, ser_in_bit};
					ser_count <= 5'h01;
					ser_state <= scpl_pkg::SER_CMD;
				end
				scpl_pkg::SER_CMD: begin
					ser_cmd <= cmd_full;
					ser_count <= cmd_done ? scpl_pkg::SER_COUNT_ZERO : ser_count + 5'h01;
					if (cmd_done) begin
						ser_state <= cmd_is_read ? scpl_pkg::SER_READ : scpl_pkg::SER_WRITE;
					end
				end
				scpl_pkg::SER_WRITE: begin
					ser_shift_in <= {ser_shift_in[14:0], ser_in_bit};
					ser_count <= data_done ? scpl_pkg::SER_COUNT_ZERO : ser_count + 5'h01;
					if (data_done) begin
						ser_state <= scpl_pkg::SER_IDLE;
					end
				end
				default: begin
					ser_count <= data_done ? scpl_pkg::SER_COUNT_ZERO : ser_count + 5'h01;
					if (data_done) begin
						ser_state <= scpl_pkg::SER_IDLE;
					end
				end
			endcase
		end
	end

	// A completed write frame becomes a one-cycle register write.
	assign ser_write_pulse = cs_active & sclk_rise & data_done & (ser_state == scpl_pkg::SER_WRITE);
	assign ser_write_addr = ser_cmd[6:0];
	assign ser_write_data = {ser_shift_in[14:0], ser_in_bit};

	// Read shifter: loaded when the command ends, advanced on falling edges.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ser_shift_out <= 16'h0000;
		end else if (cs_active && sclk_rise && cmd_done && cmd_is_read) begin
			ser_shift_out <= ser_read_word;
		end else if (cs_active && sclk_fall && ser_state == scpl_pkg::SER_READ && ser_count != scpl_pkg::SER_COUNT_ZERO) begin
			ser_shift_out <= {ser_shift_out[14:0], 1'b0};
		end
	end

	// Scan bypass: TDI captured on rising test clock, TDO on falling.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			scan_bypass <= 1'b0;
			scan_tdo <= 1'b0;
		end else if (test_mode) begin
			if (sclk_rise) begin
				scan_bypass <= ser_in_bit;
			end
			if (sclk_fall) begin
				scan_tdo <= scan_bypass;
			end
		end
	end

	// Shared serial output pin: register data in host mode, TDO in test mode.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			SHARED_SERIAL_OUT_PIN_OUT <= 1'b0;
			SHARED_SERIAL_OUT_PIN_OE_OUT <= 1'b0;
		end else begin
			SHARED_SERIAL_OUT_PIN_OUT <= test_mode ? scan_tdo : ser_shift_out[15];
			SHARED_SERIAL_OUT_PIN_OE_OUT <= test_mode | (cs_active & ser_state == scpl_pkg::SER_READ);
		end
	end

	// APB decode; every access completes in its first access cycle.
	wire apb_access = PSEL_IN & PENABLE_IN;
	wire [7:0] apb_off = 8'(PADDR_IN);
	wire addr_upper_zero = (PADDR_IN >> 8) == '0;
	wire hit_proc = addr_upper_zero && (apb_off == scpl_pkg::OFF_PROC_DISABLE);
	wire hit_ctrl = addr_upper_zero && (apb_off == scpl_pkg::OFF_CONTROL);
	wire hit_stat = addr_upper_zero && (apb_off == scpl_pkg::OFF_STATUS);
	wire hit_last = addr_upper_zero && (apb_off == scpl_pkg::OFF_LAST_WRITE);
	wire apb_mapped = hit_proc | hit_ctrl | hit_stat | hit_last;
	wire apb_wr = apb_access & PWRITE_IN;
	wire ser_wr_proc = ser_write_pulse && (ser_write_addr == scpl_pkg::SER_PROC_DISABLE);
	wire ser_wr_ctrl = ser_write_pulse && (ser_write_addr == scpl_pkg::SER_CONTROL);
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = apb_access & ~apb_mapped;
	assign PRDATA_OUT = prdata;

	// Read data mux for the APB side.
	wire [31:0] next_prdata;
	assign next_prdata = hit_proc ? {16'h0000, proc_disable} :
		hit_ctrl ? {16'h0000, control} :
		hit_stat ? {16'h0000, status} :
		hit_last ? {16'h0000, last_write} : 32'h0000_0000;

	// Read data is registered in the setup cycle, ready in the access cycle.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			prdata <= 32'h0000_0000;
		end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
			prdata <= next_prdata;
		end
	end

	// Register writes; the serial host wins a same-cycle collision.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			proc_disable <= scpl_pkg::PROC_DISABLE_RESET;
			control <= scpl_pkg::CONTROL_RESET;
			last_write <= 16'h0000;
		end else begin
			if (ser_wr_proc) begin
				proc_disable <= ser_write_data;
			end else if (apb_wr && hit_proc) begin
				proc_disable <= PWDATA_IN[15:0];
			end
			if (ser_wr_ctrl) begin
				control <= ser_write_data & scpl_pkg::CONTROL_MASK;
			end else if (apb_wr && hit_ctrl) begin
				control <= PWDATA_IN[15:0] & scpl_pkg::CONTROL_MASK;
			end
			if (ser_write_pulse) begin
				last_write <= ser_write_data;
			end
		end
	end

	// Convention and detect selection feeding the timing logic.
	wire h_config = proc_disable[scpl_pkg::H_CONFIG_BIT];
	wire timing_detect_select = control[scpl_pkg::DETECT_SEL_BIT];
	wire next_h_flag = h_sampled & pin_sync.io_en & ~timing_detect_select;

	// H is taken at each rising parallel clock edge, aligned with its word.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			h_sampled <= 1'b0;
			h_flag <= 1'b0;
			H_CONFIG_OUT <= 1'b0;
		end else begin
			if (pclk_rise) begin
				h_sampled <= pin_sync.h;
			end
			h_flag <= next_h_flag;
			H_CONFIG_OUT <= h_config;
		end
	end
	assign H_FLAG_OUT = h_flag;

	// Serial output stage: data registered, enable from the pin.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			sdo_data <= 1'b0;
			SDO_OE_OUT <= 1'b0;
		end else begin
			sdo_data <= SER_BIT_IN;
			SDO_OE_OUT <= pin_sync.out_en;
		end
	end
	assign SDO_P_OUT = sdo_data;
	assign SDO_N_OUT = ~sdo_data;
endmodule : scpl_top
`default_nettype wire
